/* File: common/tlv_write_map.vh */
// Contract
// - First block creates, replaces or deletes object
// - Freed storage returns to the pool
// - Next block appends after received bytes
// - Retransmit overwrites the previous block portion
// - Refuse unless update access is granted
// - Success on first block means storage reserved
// - No room for length gives 6A84
// - Tag held by other channel gives 6985
// - 9000 when complete, else more-data status
// - Next block after completion gives 6A86
// - Aborted transfer removes the object
// - Overlong data gives 6700, nothing changes
// - Tag out of range gives 6A80
// - Tag-only deletes; absent object is fine
// - Zero length creates an empty object
// - Out-of-sequence response fetch gives 6F00
// - Other channel command discards pending response
// - First block sets pointer, aborts open transfer
// - File change aborts an open transfer
// - Error leaves pointer and context unchanged
// - P2 b8..b7 block mode, b5..b1 file
`ifndef TLV_WRITE_MAP_VH
`define TLV_WRITE_MAP_VH

`define ADDR_CMD 8'h00
`define ADDR_TAG 8'h04
`define ADDR_LEN 8'h08
`define ADDR_CNT 8'h0C
`define ADDR_STATUS 8'h10
`define ADDR_WRPTR 8'h14
`define ADDR_POOL 8'h18

`define CMD_KIND_LO 0
`define CMD_CHAN_LO 2
`define CMD_ACCESS 4
`define CMD_PROACTIVE 5
`define CMD_TAG_ONLY 6
`define CMD_RESP_DATA 7
`define CMD_P1_LO 8
`define CMD_P2_LO 16
`define STATUS_BUSY 16

`define KIND_SET 2'h0
`define KIND_GET_RESP 2'h1
`define KIND_FILE_CHANGE 2'h2
`define KIND_OTHER 2'h3

`define MODE_NEXT 2'h0
`define MODE_RETX 2'h1
`define MODE_FIRST 2'h2

`define SW_OK 16'h9000
`define SW_MORE 16'h63F1
`define SW_MORE_PRO 16'h63F2
`define SW_NO_MEMORY 16'h6A84
`define SW_USE_COND 16'h6985
`define SW_WRONG_P1P2 16'h6A86
`define SW_WRONG_LEN 16'h6700
`define SW_BAD_DATA 16'h6A80
`define SW_ACCESS 16'h6982
`define SW_TECH 16'h6F00
`define TAG_LIST 16'h005C

`define RST_WORD 32'h0000_0000
`define RST_SW 16'h0000

`endif

/* File: hw/tlv_object_write_sequencer.v */
`include "tlv_write_map.vh"

module tlv_object_write_sequencer #(
    parameter SLOTS = 4,
    parameter SLOT_W = 2,
    parameter CHANS = 4,
    parameter LEN_W = 24,
    parameter [LEN_W-1:0] POOL_BYTES = 24'h000400,
    parameter [15:0] TAG_MIN = 16'h0001,
    parameter [15:0] TAG_MAX = 16'h7FFF
) (
    input wire ref_clk,
    input wire nrst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata
);
    localparam ST_IDLE = 2'b01;
    localparam ST_EXEC = 2'b10;
    // Decoded operation, applied in the execute cycle
    localparam OP_NONE = 3'h0;
    localparam OP_DEL = 3'h1;
    localparam OP_NEW = 3'h2;
    localparam OP_APP = 3'h3;
    localparam OP_RTX = 3'h4;
    localparam OP_ABORT = 3'h5;

    reg [1:0] state;
    reg wrPend;
    reg [7:0] wrAddr;
    reg [31:0] cmdReg;
    reg [15:0] tagReg;
    reg [LEN_W-1:0] lenReg;
    reg [LEN_W-1:0] cntReg;
    reg [15:0] statusWord;
    reg [LEN_W-1:0] wrOffset;
    reg [SLOT_W-1:0] wrSlot;
    reg [LEN_W-1:0] poolFree;
    reg respPend;
    reg [1:0] respChan;

    reg objValid [0:SLOTS-1];
    reg [15:0] objTag [0:SLOTS-1];
    reg [LEN_W-1:0] objLen [0:SLOTS-1];

    reg ctxPtr [0:CHANS-1];
    reg ctxDone [0:CHANS-1];
    reg [SLOT_W-1:0] ctxSlot [0:CHANS-1];
    reg [LEN_W-1:0] ctxRcv [0:CHANS-1];
    reg [LEN_W-1:0] ctxOff [0:CHANS-1];

    wire [1:0] kind = cmdReg[`CMD_KIND_LO+1:`CMD_KIND_LO];
    wire [1:0] chan = cmdReg[`CMD_CHAN_LO+1:`CMD_CHAN_LO];
    wire [7:0] p1 = cmdReg[`CMD_P1_LO+7:`CMD_P1_LO];
    wire [7:0] p2 = cmdReg[`CMD_P2_LO+7:`CMD_P2_LO];
    wire [1:0] mode = p2[7:6];
    wire [4:0] sfi = p2[4:0];
    wire addrPhase = hsel && htrans[1] && hready;

    // Bound check in LEN_W+1 bits so a sum never wraps
    function fits;
        input [LEN_W-1:0] base;
        input [LEN_W-1:0] add;
        input [LEN_W-1:0] limit;
        begin
            fits = ({1'b0, base} + {1'b0, add}) <= {1'b0, limit};
        end
    endfunction

    function [15:0] moreWord;
        input proactive;
        begin
            moreWord = proactive ? `SW_MORE_PRO : `SW_MORE;
        end
    endfunction

    reg hit;
    reg [SLOT_W-1:0] hitSlot;
    reg freeHit;
    reg [SLOT_W-1:0] freeSlot;
    reg lockHit;
    reg isOpen;
    reg [SLOT_W-1:0] oldSlot;
    reg [SLOT_W-1:0] useSlot;
    reg [LEN_W:0] gain;
    reg [LEN_W-1:0] curLen;
    reg [15:0] nextSw;
    reg [2:0] op;
    integer i;

    always @* begin
        hit = 1'b0;
        hitSlot = {SLOT_W{1'b0}};
        freeHit = 1'b0;
        freeSlot = {SLOT_W{1'b0}};
        lockHit = 1'b0;
        isOpen = ctxPtr[chan] && !ctxDone[chan];
        oldSlot = ctxSlot[chan];
        curLen = objLen[oldSlot];
        for (i = 0; i < SLOTS; i = i + 1) begin
            if (objValid[i] && objTag[i] == tagReg && !hit) begin
                hit = 1'b1;
                hitSlot = i[SLOT_W-1:0];
            end
            if (!objValid[i] && !freeHit) begin
                freeHit = 1'b1;
                freeSlot = i[SLOT_W-1:0];
            end
        end
        for (i = 0; i < CHANS; i = i + 1) begin
            // Another channel's pointer on this tag blocks any change
            if (i[1:0] != chan && ctxPtr[i] && objValid[ctxSlot[i]]
                    && objTag[ctxSlot[i]] == tagReg) begin
                lockHit = 1'b1;
            end
        end
        // Storage given back by the abort and by the replaced object
        gain = {1'b0, poolFree};
        if (isOpen) begin
            gain = gain + {1'b0, curLen};
        end
        if (hit && !(isOpen && hitSlot == oldSlot)) begin
            gain = gain + {1'b0, objLen[hitSlot]};
        end
        // Same tag keeps its slot; an aborted slot is reused first
        if (hit) begin
            useSlot = hitSlot;
        end else if (isOpen) begin
            useSlot = oldSlot;
        end else begin
            useSlot = freeSlot;
        end
        op = OP_NONE;
        nextSw = `SW_OK;
        // Status priority follows the order of the checks below
        case (kind)
            `KIND_SET: begin
                if (!cmdReg[`CMD_ACCESS]) begin
                    nextSw = `SW_ACCESS;
                end else if (p1 != 8'h00 || mode == 2'h3) begin
                    nextSw = `SW_WRONG_P1P2;
                end else if (mode == `MODE_FIRST) begin
                    if (tagReg < TAG_MIN || tagReg > TAG_MAX || tagReg == `TAG_LIST) begin
                        nextSw = `SW_BAD_DATA;
                    end else if (lockHit) begin
                        nextSw = `SW_USE_COND;
                    end else if (cmdReg[`CMD_TAG_ONLY]) begin
                        op = OP_DEL;
                    end else if (cntReg > lenReg) begin
                        nextSw = `SW_WRONG_LEN;
                    end else if (!hit && !isOpen && !freeHit) begin
                        nextSw = `SW_NO_MEMORY;
                    end else if ({1'b0, lenReg} > gain) begin
                        nextSw = `SW_NO_MEMORY;
                    end else begin
                        op = OP_NEW;
                        if (cntReg != lenReg) begin
                            nextSw = moreWord(cmdReg[`CMD_PROACTIVE]);
                        end
                    end
                end else if (sfi != 5'h00 || !isOpen) begin
                    nextSw = `SW_WRONG_P1P2;
                end else if (mode == `MODE_NEXT) begin
                    if (!fits(ctxRcv[chan], cntReg, curLen)) begin
                        nextSw = `SW_WRONG_LEN;
                    end else begin
                        op = OP_APP;
                        if (ctxRcv[chan] + cntReg != curLen) begin
                            nextSw = moreWord(cmdReg[`CMD_PROACTIVE]);
                        end
                    end
                end else begin
                    if (!fits(ctxOff[chan], cntReg, curLen)) begin
                        nextSw = `SW_WRONG_LEN;
                    end else begin
                        op = OP_RTX;
                        if (ctxOff[chan] + cntReg != curLen) begin
                            nextSw = moreWord(cmdReg[`CMD_PROACTIVE]);
                        end
                    end
                end
            end
            `KIND_GET_RESP: begin
                if (!(respPend && respChan == chan)) begin
                    nextSw = `SW_TECH;
                end
            end
            `KIND_FILE_CHANGE: begin
                op = OP_ABORT;
            end
            default: begin
                op = OP_NONE;
            end
        endcase
    end

    // Bus side: zero wait states, registered read data
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= `RST_WORD;
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wrPend <= addrPhase && hwrite;
            // Upper address bits not decoded, so words alias every 256 bytes
            wrAddr <= {haddr[7:2], 2'b00};
            if (addrPhase && !hwrite) begin
                case ({haddr[7:2], 2'b00})
                    `ADDR_CMD: hrdata <= cmdReg;
                    `ADDR_TAG: hrdata <= {16'h0000, tagReg};
                    `ADDR_LEN: hrdata <= {{(32-LEN_W){1'b0}}, lenReg};
                    `ADDR_CNT: hrdata <= {{(32-LEN_W){1'b0}}, cntReg};
                    `ADDR_STATUS: hrdata <= {15'h0000, state == ST_EXEC, statusWord};
                    `ADDR_WRPTR: hrdata <= {{(8-SLOT_W){1'b0}}, wrSlot, wrOffset};
                    `ADDR_POOL: hrdata <= {{(32-LEN_W){1'b0}}, poolFree};
                    default: hrdata <= `RST_WORD;
                endcase
            end else begin
                hrdata <= `RST_WORD;
            end
        end
    end

    // Command registers and execution
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            cmdReg <= `RST_WORD;
            tagReg <= 16'h0000;
            lenReg <= {LEN_W{1'b0}};
            cntReg <= {LEN_W{1'b0}};
            statusWord <= `RST_SW;
            wrOffset <= {LEN_W{1'b0}};
            wrSlot <= {SLOT_W{1'b0}};
            poolFree <= POOL_BYTES;
            respPend <= 1'b0;
            respChan <= 2'h0;
            for (i = 0; i < SLOTS; i = i + 1) begin
                objValid[i] <= 1'b0;
                objTag[i] <= 16'h0000;
                objLen[i] <= {LEN_W{1'b0}};
            end
            for (i = 0; i < CHANS; i = i + 1) begin
                ctxPtr[i] <= 1'b0;
                ctxDone[i] <= 1'b0;
                ctxSlot[i] <= {SLOT_W{1'b0}};
                ctxRcv[i] <= {LEN_W{1'b0}};
                ctxOff[i] <= {LEN_W{1'b0}};
            end
        end else begin
            case (state)
                ST_IDLE: begin
                    if (wrPend) begin
                        case (wrAddr)
                            `ADDR_CMD: begin
                                cmdReg <= hwdata;
                                state <= ST_EXEC;
                            end
                            `ADDR_TAG: tagReg <= hwdata[15:0];
                            `ADDR_LEN: lenReg <= hwdata[LEN_W-1:0];
                            `ADDR_CNT: cntReg <= hwdata[LEN_W-1:0];
                            default: state <= ST_IDLE;
                        endcase
                    end
                end
                ST_EXEC: begin
                    // Writes during this cycle are dropped; software polls busy first
                    state <= ST_IDLE;
                    statusWord <= nextSw;
                    // Any command, on any channel, replaces the pending response
                    respPend <= (kind == `KIND_OTHER) && cmdReg[`CMD_RESP_DATA];
                    respChan <= chan;
                    case (op)
                        OP_DEL: begin
                            if (isOpen) begin
                                objValid[oldSlot] <= 1'b0;
                            end
                            if (hit) begin
                                objValid[hitSlot] <= 1'b0;
                            end
                            poolFree <= gain[LEN_W-1:0];
                            ctxPtr[chan] <= 1'b0;
                        end
                        // Slot and pool are taken only here, after every check passed
                        OP_NEW: begin
                            if (isOpen && oldSlot != useSlot) begin
                                objValid[oldSlot] <= 1'b0;
                            end
                            objValid[useSlot] <= 1'b1;
                            objTag[useSlot] <= tagReg;
                            objLen[useSlot] <= lenReg;
                            poolFree <= gain[LEN_W-1:0] - lenReg;
                            ctxPtr[chan] <= 1'b1;
                            ctxSlot[chan] <= useSlot;
                            ctxRcv[chan] <= cntReg;
                            ctxOff[chan] <= {LEN_W{1'b0}};
                            ctxDone[chan] <= cntReg == lenReg;
                            wrSlot <= useSlot;
                            wrOffset <= {LEN_W{1'b0}};
                        end
                        // Block offset kept so a retransmit can go back to it
                        OP_APP: begin
                            ctxOff[chan] <= ctxRcv[chan];
                            ctxRcv[chan] <= ctxRcv[chan] + cntReg;
                            ctxDone[chan] <= ctxRcv[chan] + cntReg == curLen;
                            wrSlot <= oldSlot;
                            wrOffset <= ctxRcv[chan];
                        end
                        OP_RTX: begin
                            ctxRcv[chan] <= ctxOff[chan] + cntReg;
                            ctxDone[chan] <= ctxOff[chan] + cntReg == curLen;
                            wrSlot <= oldSlot;
                            wrOffset <= ctxOff[chan];
                        end
                        OP_ABORT: begin
                            if (isOpen) begin
                                objValid[oldSlot] <= 1'b0;
                                poolFree <= poolFree + curLen;
                            end
                            ctxPtr[chan] <= 1'b0;
                        end
                        default: begin
                            // Errors leave every context as it was
                            state <= ST_IDLE;
                        end
                    endcase
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // tlv_object_write_sequencer

/* File: test/tlv_write_assertions.sv */
`include "tlv_write_map.vh"

module tlv_write_checker #(
    parameter LEN_W = 24,
    parameter [LEN_W-1:0] POOL_BYTES = 24'h000400
) (
    input wire ref_clk,
    input wire nrst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata
);
    wire take = hsel & htrans[1] & hready;
    logic rdPend;
    logic wrPend;
    logic wrPrev;
    logic exec;
    logic [5:0] word;
    logic [15:0] lastTag;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdPend <= 1'b0;
            wrPend <= 1'b0;
            wrPrev <= 1'b0;
            exec <= 1'b0;
            word <= 6'h00;
            lastTag <= 16'h0000;
        end else begin
            rdPend <= take & ~hwrite;
            wrPend <= take & hwrite;
            wrPrev <= wrPend;
            exec <= wrPend && word == 6'h00;
            if (take) begin
                word <= haddr[7:2];
            end
            // Writes ending in the execute cycle are dropped
            if (wrPend && !exec && word == 6'h01) begin
                lastTag <= hwdata[15:0];
            end
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    chk_ready_always: assert property (hreadyout)
        else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    chk_rdata_quiet: assert property (!rdPend |-> hrdata == 32'h00000000)
        else $error("hrdata outside read");
    chk_unmapped_zero: assert property (rdPend && word > 6'h06 |-> hrdata == 32'h00000000)
        else $error("unmapped read not zero");
    chk_tag_readback: assert property (rdPend && word == 6'h01 && !wrPrev |-> hrdata[15:0] == lastTag)
        else $error("tag readback wrong");
    chk_busy_flag: assert property ((take && hwrite && haddr[7:2] == 6'h00) ##2
        (take && !hwrite && haddr[7:2] == 6'h04) |=> hrdata[16])
        else $error("busy not shown");
    chk_status_known: assert property (rdPend && word == 6'h04 && !hrdata[16] |->
        hrdata[15:0] inside {16'h0000, `SW_OK, `SW_MORE, `SW_MORE_PRO, `SW_NO_MEMORY,
        `SW_USE_COND, `SW_WRONG_P1P2, `SW_WRONG_LEN, `SW_BAD_DATA, `SW_ACCESS, `SW_TECH})
        else $error("unknown status word");
    chk_pool_bound: assert property (rdPend && word == 6'h06 |->
        hrdata[LEN_W-1:0] <= POOL_BYTES)
        else $error("pool above size");
endmodule // tlv_write_checker

bind tlv_object_write_sequencer tlv_write_checker #(.LEN_W(LEN_W), .POOL_BYTES(POOL_BYTES)) chk (
    .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata));

/* File: test/terminal_model.sv */
`include "tlv_write_map.vh"

module terminal_model (
    input wire ref_clk,
    input wire hready,
    input wire [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        hsel <= 1'b0;
        haddr <= 32'h00000000;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        hwdata <= 32'h00000000;
    end

    function automatic logic [31:0] cmdWord(input logic [1:0] kind, input logic [1:0] ch,
            input logic [3:0] flg, input logic [7:0] p1, input logic [7:0] p2);
        return {8'h00, p2, p1, flg, ch, kind};
    endfunction

    // Entered just after a rising edge; waits on hready, never on a cycle count
    task automatic addrPhase(input logic [7:0] a, input logic w);
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
    endtask

    task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
        addrPhase(a, 1'b1);
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
    endtask

    task automatic busRead(input logic [7:0] a, output logic [31:0] d);
        addrPhase(a, 1'b0);
        do @(posedge ref_clk); while (hready !== 1'b1);
        d = hrdata;
    endtask

    // Polls busy; a status read landing in the execute cycle is repeated
    task automatic runCmd(input logic [31:0] cmd, output logic [15:0] sw);
        logic [31:0] r;
        busWrite(`ADDR_CMD, cmd);
        do busRead(`ADDR_STATUS, r); while (r[16] !== 1'b0);
        sw = r[15:0];
    endtask

    task automatic setData(input logic [1:0] ch, input logic [7:0] p2, input logic [15:0] tag,
            input logic [23:0] len, input logic [23:0] cnt, input logic [3:0] flg,
            output logic [15:0] sw);
        busWrite(`ADDR_TAG, {16'h0000, tag});
        busWrite(`ADDR_LEN, {8'h00, len});
        busWrite(`ADDR_CNT, {8'h00, cnt});
        runCmd(cmdWord(2'h0, ch, flg, 8'h00, p2), sw);
    endtask
endmodule // terminal_model

/* File: test/tb.sv */
`include "tlv_write_map.vh"

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [23:0] POOL = 24'h000020;
    localparam logic [3:0] ACC = 4'h1;
    localparam int LIMIT = 20000;
    logic refClk = 1'b0;
    logic nrst = 1'b0;
    wire hsel;
    wire [31:0] haddr;
    wire [1:0] htrans;
    wire hwrite;
    wire [2:0] hsize;
    wire [31:0] hwdata;
    wire hreadyout;
    wire hresp;
    wire [31:0] hrdata;
    logic [31:0] rd;
    logic [15:0] sw;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;

    tlv_object_write_sequencer #(.POOL_BYTES(POOL)) DUT (
        .ref_clk(refClk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

    terminal_model term (
        .ref_clk(refClk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    initial begin
        forever #50 refClk = ~refClk;
    end

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic sd(input logic [1:0] ch, input logic [7:0] p2, input logic [15:0] tag,
            input logic [23:0] len, input logic [23:0] cnt, input logic [3:0] flg,
            input logic [15:0] exp);
        term.setData(ch, p2, tag, len, cnt, flg, sw);
        check("status", {16'h0000, sw}, {16'h0000, exp});
    endtask

    task automatic rc(input logic [31:0] cmd, input logic [15:0] exp);
        term.runCmd(cmd, sw);
        check("status", {16'h0000, sw}, {16'h0000, exp});
    endtask

    task automatic poolIs(input logic [23:0] exp);
        term.busRead(`ADDR_POOL, rd);
        check("pool", rd, {8'h00, exp});
    endtask

    task automatic ptrIs(input logic [23:0] exp);
        term.busRead(`ADDR_WRPTR, rd);
        check("offset", {8'h00, rd[23:0]}, {8'h00, exp});
    endtask

    task automatic midReset();
        nrst <= 1'b0;
        repeat (2) @(posedge refClk);
        nrst <= 1'b1;
        @(posedge refClk);
        poolIs(POOL);
        sd(2'h0, 8'h80, 16'h0030, POOL, 24'h000000, ACC, `SW_MORE);
        poolIs(24'h000000);
    endtask

    task automatic startState();
        poolIs(POOL);
        term.busWrite(`ADDR_TAG, 32'h00001234);
        term.busRead(`ADDR_TAG, rd);
        check("tag", rd, 32'h00001234);
        term.busRead(8'h1C, rd);
        check("unmapped", rd, 32'h00000000);
    endtask

    task automatic createObject();
        sd(2'h0, 8'h80, 16'h0010, 24'h000008, 24'h000003, ACC, `SW_MORE);
        poolIs(POOL - 24'h000008);
        sd(2'h0, 8'h00, 16'h0010, 24'h000008, 24'h000005, ACC, `SW_OK);
        ptrIs(24'h000003);
        sd(2'h0, 8'h00, 16'h0010, 24'h000008, 24'h000001, ACC, `SW_WRONG_P1P2);
    endtask

    task automatic memoryUse();
        sd(2'h0, 8'h80, 16'h0011, POOL, 24'h000000, ACC, `SW_NO_MEMORY);
        sd(2'h0, 8'h80, 16'h0010, 24'h000000, 24'h000000, 4'h5, `SW_OK);
        poolIs(POOL);
        sd(2'h0, 8'h80, 16'h0010, 24'h000000, 24'h000000, 4'h5, `SW_OK);
        sd(2'h0, 8'h80, 16'h0011, 24'h000000, 24'h000000, ACC, `SW_OK);
        poolIs(POOL);
    endtask

    task automatic overflowRetx();
        sd(2'h0, 8'h80, 16'h0012, 24'h000004, 24'h000006, ACC, `SW_WRONG_LEN);
        sd(2'h0, 8'h80, 16'h0012, 24'h000004, 24'h000002, 4'h3, `SW_MORE_PRO);
        sd(2'h0, 8'h00, 16'h0012, 24'h000004, 24'h000005, ACC, `SW_WRONG_LEN);
        sd(2'h0, 8'h01, 16'h0012, 24'h000004, 24'h000001, ACC, `SW_WRONG_P1P2);
        sd(2'h0, 8'h40, 16'h0012, 24'h000004, 24'h000002, ACC, `SW_MORE);
        ptrIs(24'h000000);
        sd(2'h0, 8'h00, 16'h0012, 24'h000004, 24'h000002, ACC, `SW_OK);
        ptrIs(24'h000002);
        poolIs(POOL - 24'h000004);
    endtask

    task automatic badCommands();
        sd(2'h3, 8'h80, 16'h0013, 24'h000001, 24'h000001, 4'h0, `SW_ACCESS);
        rc(term.cmdWord(2'h0, 2'h3, ACC, 8'h01, 8'h80), `SW_WRONG_P1P2);
        sd(2'h3, 8'hC0, 16'h0013, 24'h000001, 24'h000001, ACC, `SW_WRONG_P1P2);
        sd(2'h3, 8'h80, `TAG_LIST, 24'h000001, 24'h000001, ACC, `SW_BAD_DATA);
        sd(2'h3, 8'h80, 16'h0000, 24'h000001, 24'h000001, ACC, `SW_BAD_DATA);
    endtask

    task automatic channelLock();
        sd(2'h0, 8'h80, 16'h0020, 24'h000004, 24'h000000, ACC, `SW_MORE);
        sd(2'h1, 8'h80, 16'h0020, 24'h000004, 24'h000004, ACC, `SW_USE_COND);
        poolIs(POOL - 24'h000008);
        rc(term.cmdWord(2'h2, 2'h0, 4'h0, 8'h00, 8'h00), `SW_OK);
        poolIs(POOL - 24'h000004);
        sd(2'h1, 8'h80, 16'h0020, 24'h000004, 24'h000004, ACC, `SW_OK);
    endtask

    task automatic responseFetch();
        rc(term.cmdWord(2'h3, 2'h2, 4'h8, 8'h00, 8'h00), `SW_OK);
        rc(term.cmdWord(2'h1, 2'h2, 4'h0, 8'h00, 8'h00), `SW_OK);
        rc(term.cmdWord(2'h1, 2'h2, 4'h0, 8'h00, 8'h00), `SW_TECH);
        rc(term.cmdWord(2'h3, 2'h2, 4'h8, 8'h00, 8'h00), `SW_OK);
        rc(term.cmdWord(2'h3, 2'h3, 4'h0, 8'h00, 8'h00), `SW_OK);
        rc(term.cmdWord(2'h1, 2'h2, 4'h0, 8'h00, 8'h00), `SW_TECH);
        term.busWrite(`ADDR_CMD, term.cmdWord(2'h3, 2'h2, 4'h0, 8'h00, 8'h00));
        term.busRead(`ADDR_STATUS, rd);
        check("busy", {31'h00000000, rd[16]}, 32'h00000001);
    endtask

    task automatic restartSame();
        sd(2'h0, 8'h80, 16'h0030, 24'h000008, 24'h000002, ACC, `SW_MORE);
        sd(2'h0, 8'h80, 16'h0030, 24'h000008, 24'h000002, ACC, `SW_MORE);
        poolIs(POOL - 24'h000010);
        sd(2'h0, 8'h00, 16'h0030, 24'h000008, 24'h000007, ACC, `SW_WRONG_LEN);
        sd(2'h0, 8'h00, 16'h0030, 24'h000008, 24'h000006, ACC, `SW_OK);
    endtask

    always @(posedge refClk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            test_done();
        end
    end

    initial begin
        repeat (8) @(posedge refClk);
        nrst <= 1'b1;
        @(posedge refClk);
        startState();
        createObject();
        memoryUse();
        overflowRetx();
        badCommands();
        channelLock();
        responseFetch();
        restartSame();
        midReset();
        test_done();
    end
endmodule // tb
